/* plld_defs.svh */
// constants for the second loop lock detector block
// Summary of operation
// - pump float bit at 1 floats the charge pump output; at 0 it drives.
// - with force-on at 0, detector runs only while a status pin selects its lock.
// - with force-on at 1, detector always runs whatever the pin routing.
// - while the detector runs, its lock state reads back over the register port.
// - qualify count is 14 bits: high six at lock_count_high[5:0], low eight at lock_count_low.
// - lock asserts only after the programmed count of consecutive in-window comparisons.
`ifndef PLLD_DEFS_SVH
`define PLLD_DEFS_SVH

// register addresses
`define PLLD_ADDR_CTRL 13'h0169
`define PLLD_ADDR_CNT_HI 13'h016A
`define PLLD_ADDR_CNT_LO 13'h016B
`define PLLD_ADDR_STATUS 13'h0183

// control fields
`define PLLD_CTRL_FORCE_BIT 0
`define PLLD_CTRL_FLOAT_BIT 1
`define PLLD_STATUS_LOCK_BIT 0

// reset values
`define PLLD_RST_CNT_HI 6'h20
`define PLLD_RST_CNT_LO 8'h00
`define PLLD_RST_CTRL 2'h0
`define PLLD_RST_DATA 8'h00

// status pin selector codes that carry this loop's lock
`define PLLD_SEL_LOOP2 5'h02
`define PLLD_SEL_BOTH 5'h03

// counter constants
`define PLLD_CNT_ZERO 14'h0000
`define PLLD_CNT_ONE 14'h0001

`endif

/* plld_pkg.sv */
// types for the second loop lock detector block
package plld_pkg;

    typedef enum logic [0:0] {
        PLLD_HUNT = 1'b0,
        PLLD_LOCKED = 1'b1
    } plld_mode_t;

    typedef struct packed {
        logic [13:0] count;
        plld_mode_t mode;
    } plld_cnt_state_t;

    typedef struct packed {
        logic [5:0] cnt_hi;
        logic [7:0] cnt_lo;
        logic pump_float;
        logic force_on;
        logic run;
        logic pump_drive;
        logic lock;
        logic [7:0] rdata;
        logic rvalid;
    } plld_top_state_t;

endpackage

/* plld_if.sv */
// link between register front end and lock counter
`timescale 1ns/1ps
interface plld_if;
    logic run;
    logic cmp_valid;
    logic in_window;
    logic [13:0] target;
    logic lock;
    logic [13:0] count;

    modport ctrl (
        output run,
        output cmp_valid,
        output in_window,
        output target,
        input lock,
        input count
    );

    modport cnt (
        input run,
        input cmp_valid,
        input in_window,
        input target,
        output lock,
        output count
    );
endinterface

/* plld_counter.sv */
// consecutive in-window counter that qualifies lock
`timescale 1ns/1ps
`include "plld_defs.svh"
module plld_counter (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // link to front end
    plld_if.cnt lk
);
    plld_pkg::plld_cnt_state_t st;
    plld_pkg::plld_cnt_state_t next_st;
    logic [13:0] inc;

    assign inc = st.count + `PLLD_CNT_ONE;

    always_comb begin
        next_st = st;
        if (!lk.run || (lk.cmp_valid && !lk.in_window)) begin
            next_st.count = `PLLD_CNT_ZERO;
            next_st.mode = plld_pkg::PLLD_HUNT;
        end else if (lk.cmp_valid && st.mode == plld_pkg::PLLD_HUNT) begin
            next_st.count = inc;
            if (lk.target != `PLLD_CNT_ZERO && inc >= lk.target) begin
                next_st.mode = plld_pkg::PLLD_LOCKED;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st.count <= `PLLD_CNT_ZERO;
            st.mode <= plld_pkg::PLLD_HUNT;
        end else begin
            st <= next_st;
        end
    end

    assign lk.lock = (st.mode == plld_pkg::PLLD_LOCKED);
    assign lk.count = st.count;

    AST_LOCK_AFTER_COUNT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(lk.lock) |-> (lk.count >= lk.target) && lk.target != `PLLD_CNT_ZERO && $past(lk.cmp_valid))
        else $error("lock rose before the qualify count");

    AST_OUT_OF_WINDOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        lk.run && lk.cmp_valid && !lk.in_window |=> !lk.lock && lk.count == `PLLD_CNT_ZERO)
        else $error("out-of-window comparison did not clear the detector");

    AST_LOCK_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        lk.lock && lk.run && !(lk.cmp_valid && !lk.in_window) |=> lk.lock)
        else $error("lock dropped without an out-of-window comparison");

    AST_COUNT_STEPS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        lk.run && lk.cmp_valid && lk.in_window && !lk.lock |=> lk.count == $past(lk.count) + `PLLD_CNT_ONE)
        else $error("in-window comparison did not advance the count");
endmodule // plld_counter

/* plld_top.sv */
// second loop lock detector with pump float and register port
`timescale 1ns/1ps
`include "plld_defs.svh"
module plld_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [12:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // status pin selectors
    input wire logic [4:0] status_pin1_select_i,
    input wire logic [4:0] status_pin2_select_i,
    // phase comparator
    input wire logic phase_cmp_valid_i,
    input wire logic phase_in_window_i,
    // outputs
    output logic pump_drive_en_o,
    output logic digital_lock_detect_o,
    output logic detector_run_o
);
    plld_pkg::plld_top_state_t st;
    plld_pkg::plld_top_state_t next_st;

    plld_if lk ();

    // selector code carries this loop's lock
    function automatic logic sel_carries_lock(input logic [4:0] sel);
        sel_carries_lock = (sel == `PLLD_SEL_LOOP2) || (sel == `PLLD_SEL_BOTH);
    endfunction

    // register read decode
    function automatic logic [7:0] read_reg(
        input logic [12:0] addr,
        input plld_pkg::plld_top_state_t s,
        input logic lock
    );
        read_reg = `PLLD_RST_DATA;
        unique case (addr)
            `PLLD_ADDR_CTRL: begin
                read_reg[`PLLD_CTRL_FORCE_BIT] = s.force_on;
                read_reg[`PLLD_CTRL_FLOAT_BIT] = s.pump_float;
            end
            `PLLD_ADDR_CNT_HI: begin
                read_reg[5:0] = s.cnt_hi;
            end
            `PLLD_ADDR_CNT_LO: begin
                read_reg = s.cnt_lo;
            end
            `PLLD_ADDR_STATUS: begin
                read_reg[`PLLD_STATUS_LOCK_BIT] = lock && s.run;
            end
            default: begin
                read_reg = `PLLD_RST_DATA;
            end
        endcase
    endfunction

    logic pin_routed;
    assign pin_routed = sel_carries_lock(status_pin1_select_i) || sel_carries_lock(status_pin2_select_i);

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `PLLD_ADDR_CTRL: begin
                    next_st.force_on = reg_wdata_i[`PLLD_CTRL_FORCE_BIT];
                    next_st.pump_float = reg_wdata_i[`PLLD_CTRL_FLOAT_BIT];
                end
                `PLLD_ADDR_CNT_HI: begin
                    next_st.cnt_hi = reg_wdata_i[5:0];
                end
                `PLLD_ADDR_CNT_LO: begin
                    next_st.cnt_lo = reg_wdata_i;
                end
                default: begin
                    next_st.cnt_lo = st.cnt_lo;
                end
            endcase
        end
        if (reg_rd_i) begin
            next_st.rdata = read_reg(reg_addr_i, st, lk.lock);
            next_st.rvalid = 1'b1;
        end
        next_st.run = next_st.force_on || pin_routed;
        next_st.pump_drive = !next_st.pump_float;
        next_st.lock = lk.lock;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st.cnt_hi <= `PLLD_RST_CNT_HI;
            st.cnt_lo <= `PLLD_RST_CNT_LO;
            {st.pump_float, st.force_on} <= `PLLD_RST_CTRL;
            st.run <= 1'b0;
            st.pump_drive <= 1'b1;
            st.lock <= 1'b0;
            st.rdata <= `PLLD_RST_DATA;
            st.rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign lk.run = st.run;
    assign lk.cmp_valid = phase_cmp_valid_i;
    assign lk.in_window = phase_in_window_i;
    assign lk.target = {st.cnt_hi, st.cnt_lo};

    plld_counter u_counter (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .lk(lk.cnt)
    );

    assign reg_rdata_o = st.rdata;
    assign reg_rvalid_o = st.rvalid;
    assign pump_drive_en_o = st.pump_drive;
    assign digital_lock_detect_o = st.lock;
    assign detector_run_o = st.run;

    AST_PUMP_FLOAT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == `PLLD_ADDR_CTRL
        |=> pump_drive_en_o == !$past(reg_wdata_i[`PLLD_CTRL_FLOAT_BIT]))
        else $error("pump drive does not follow the float bit");

    AST_RUN_GATED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !st.force_on && !pin_routed ##1 !st.force_on |-> !detector_run_o ##1 !lk.lock)
        else $error("detector ran with no pin routing and no force");

    AST_RUN_FORCED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        st.force_on |=> detector_run_o || !st.force_on)
        else $error("forced detector is not running");

    AST_READBACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == `PLLD_ADDR_STATUS && st.run
        |=> reg_rvalid_o && reg_rdata_o[`PLLD_STATUS_LOCK_BIT] == $past(lk.lock))
        else $error("lock readback wrong");

    AST_CNT_HI_RB: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == `PLLD_ADDR_CNT_HI ##1 reg_rd_i && reg_addr_i == `PLLD_ADDR_CNT_HI && !reg_wr_i
        |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
        else $error("count high readback wrong");

    AST_TARGET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == `PLLD_ADDR_CNT_LO |=> lk.target[7:0] == $past(reg_wdata_i))
        else $error("count low not applied to target");
endmodule // plld_top

/* pll_lock_detect_counter_bench.sv */
// self-checking bench for the second loop lock detector
`timescale 1ns/1ps
`include "plld_defs.svh"
module pll_lock_detect_counter_bench;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [12:0] reg_addr_i = 13'h0000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [4:0] status_pin1_select_i = 5'h00;
    logic [4:0] status_pin2_select_i = 5'h00;
    logic phase_cmp_valid_i = 1'b0;
    logic phase_in_window_i = 1'b0;
    logic pump_drive_en_o;
    logic digital_lock_detect_o;
    logic detector_run_o;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] expq[$];
    logic [31:0] rnd = 32'hD1D7;
    logic [13:0] target;

    plld_top i_dut (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .status_pin1_select_i(status_pin1_select_i),
        .status_pin2_select_i(status_pin2_select_i),
        .phase_cmp_valid_i(phase_cmp_valid_i),
        .phase_in_window_i(phase_in_window_i),
        .pump_drive_en_o(pump_drive_en_o),
        .digital_lock_detect_o(digital_lock_detect_o),
        .detector_run_o(detector_run_o)
    );

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic tick();
        @(posedge clk_sys_i);
        #5;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick();
        reg_wr_i = 1'b0;
        tick();
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        tick();
        reg_rd_i = 1'b0;
        tick();
    endtask

    // n back-to-back comparisons with valid held high throughout
    task automatic cmp_run(input logic [13:0] n, input logic in_win);
        phase_cmp_valid_i = 1'b1;
        phase_in_window_i = in_win;
        repeat (n) tick();
        phase_cmp_valid_i = 1'b0;
    endtask

    task automatic lock_seq(input logic [13:0] n);
        cmp_run(n - 14'h0001, 1'b1);
        tick();
        tick();
        check({7'h00, digital_lock_detect_o}, 8'h00);
        cmp_run(14'h0001, 1'b1);
        tick();
        check({7'h00, digital_lock_detect_o}, 8'h01);
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // read answers against queued expectations
    always @(negedge clk_sys_i) begin
        if (resetn_i && reg_rvalid_o === 1'b1) begin
            if (expq.size() == 0) begin
                check({7'h00, reg_rvalid_o}, 8'h00);
            end else begin
                check(reg_rdata_o, expq.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) tick();
        n_mismatch++;
        $display("BAD t=%0t run did not finish in time", $time);
        print_verdict();
    end

    initial begin
        repeat (3) tick();
        resetn_i = 1'b1;
        check({7'h00, pump_drive_en_o}, 8'h01);
        rd(`PLLD_ADDR_CTRL, 8'h00);
        rd(`PLLD_ADDR_CNT_HI, 8'h20);
        rd(`PLLD_ADDR_CNT_LO, 8'h00);
        rd(13'h0000, 8'h00);
        wr(`PLLD_ADDR_CNT_HI, 8'hFF);
        rd(`PLLD_ADDR_CNT_HI, 8'h3F);
        rnd = lfsr(rnd);
        wr(`PLLD_ADDR_CNT_LO, rnd[7:0]);
        rd(`PLLD_ADDR_CNT_LO, rnd[7:0]);
        wr(`PLLD_ADDR_CTRL, 8'h02);
        tick();
        check({7'h00, pump_drive_en_o}, 8'h00);
        wr(`PLLD_ADDR_CTRL, 8'h00);
        tick();
        check({7'h00, pump_drive_en_o}, 8'h01);
        for (int i = 0; i < 10; i++) begin
            status_pin1_select_i = (i < 5) ? 5'(i) : 5'h00;
            status_pin2_select_i = (i < 5) ? 5'h00 : 5'(i - 5);
            tick();
            tick();
            check({7'h00, detector_run_o}, {7'h00, (i % 5 == 2) || (i % 5 == 3)});
        end
        status_pin2_select_i = 5'h00;
        rnd = lfsr(rnd);
        target = {11'h000, rnd[2:0]} + 14'h0002;
        wr(`PLLD_ADDR_CNT_HI, 8'h00);
        wr(`PLLD_ADDR_CNT_LO, {2'h0, target[5:0]});
        wr(`PLLD_ADDR_CTRL, 8'h01);
        tick();
        tick();
        check({7'h00, detector_run_o}, 8'h01);
        lock_seq(target);
        rd(`PLLD_ADDR_STATUS, 8'h01);
        wr(`PLLD_ADDR_STATUS, 8'hFE);
        rd(`PLLD_ADDR_STATUS, 8'h01);
        cmp_run(14'h0001, 1'b0);
        tick();
        check({7'h00, digital_lock_detect_o}, 8'h00);
        rd(`PLLD_ADDR_STATUS, 8'h00);
        lock_seq(target);
        wr(`PLLD_ADDR_CTRL, 8'h00);
        tick();
        tick();
        check({7'h00, detector_run_o}, 8'h00);
        check({7'h00, digital_lock_detect_o}, 8'h00);
        rd(`PLLD_ADDR_STATUS, 8'h00);
        tick();
        check(8'(expq.size()), 8'h00);
        print_verdict();
    end
endmodule // pll_lock_detect_counter_bench
